//--- hha_averager.sv
// Functional notes
// - averaging period is a 28-bit unsigned millisecond count
// - holdover word is the mean of tuning-word samples over the period
// - periods from one millisecond up to the full 28-bit count work
// - with lock-delay bit set, averaging waits for frequency lock
// - after lock with delay bit set, wait the hold-off time too
// - with lock-delay bit clear, averaging runs whatever the lock state
// - hold-off is an 8-bit millisecond count delaying accumulation
// - a zero hold-off skips the delay entirely
//
// The AHB-Lite slave port is this design's own decision.
module hha_averager #(
    parameter int MS_TICK_CYCLES = hha_pkg::MS_CYCLES // cycles per ms tick
) (
    input wire logic hclk, // bus and core clock
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // always ready
    output logic hresp, // always okay
    input wire logic [hha_pkg::TW_W-1:0] tuning_word, // loop tuning word
    input wire logic freq_locked, // frequency lock from detector
    output hha_pkg::hha_avg_s holdover, // averaged word and valid
    output logic averaging // accumulation running
);

    // ---------------- bus slave ----------------
    logic wr_pend_q, wr_pend_d;
    logic [31:0] wr_addr_q, wr_addr_d;
    logic [31:0] rdata_q, rdata_d;
    hha_pkg::hha_cfg_s cfg_q, cfg_d;
    hha_pkg::hha_state_e state_q, state_d;
    hha_pkg::hha_avg_s avg_q, avg_d;
    logic div_busy_q, div_busy_d;
    logic addr_ok;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;
    assign addr_ok = hsel && hready && (htrans == hha_pkg::HTRANS_NONSEQ);

    // capture writes for the data phase; reads answer from a flop next cycle
    always_comb begin
        wr_pend_d = addr_ok && hwrite;
        wr_addr_d = addr_ok ? haddr : wr_addr_q;
        rdata_d = rdata_q;
        if (addr_ok && !hwrite) begin
            if (haddr == hha_pkg::addr_of(hha_pkg::IDX_PER0)) begin
                rdata_d = {24'h000000, cfg_q.period[7:0]};
            end else if (haddr == hha_pkg::addr_of(hha_pkg::IDX_PER1)) begin
                rdata_d = {24'h000000, cfg_q.period[15:8]};
            end else if (haddr == hha_pkg::addr_of(hha_pkg::IDX_PER2)) begin
                rdata_d = {24'h000000, cfg_q.period[23:16]};
            end else if (haddr == hha_pkg::addr_of(hha_pkg::IDX_PER3)) begin
                rdata_d = {28'h0000000, cfg_q.period[27:24]}; // upper nibble reserved
            end else if (haddr == hha_pkg::addr_of(hha_pkg::IDX_COND)) begin
                rdata_d = {26'h0, cfg_q.cond};
            end else if (haddr == hha_pkg::addr_of(hha_pkg::IDX_HOLD)) begin
                rdata_d = {24'h000000, cfg_q.holdoff};
            end else if (haddr == hha_pkg::addr_of(hha_pkg::IDX_STAT)) begin
                rdata_d = {28'h0000000, div_busy_q, avg_q.valid, state_q};
            end else if (haddr == hha_pkg::addr_of(hha_pkg::IDX_AVG)) begin
                rdata_d = avg_q.word;
            end else begin
                rdata_d = 32'h00000000; // unmapped reads as zero
            end
        end
    end

    // configuration writes, low byte lane only
    always_comb begin
        cfg_d = cfg_q;
        if (wr_pend_q) begin
            if (wr_addr_q == hha_pkg::addr_of(hha_pkg::IDX_PER0)) begin
                cfg_d.period[7:0] = hwdata[7:0];
            end else if (wr_addr_q == hha_pkg::addr_of(hha_pkg::IDX_PER1)) begin
                cfg_d.period[15:8] = hwdata[7:0];
            end else if (wr_addr_q == hha_pkg::addr_of(hha_pkg::IDX_PER2)) begin
                cfg_d.period[23:16] = hwdata[7:0];
            end else if (wr_addr_q == hha_pkg::addr_of(hha_pkg::IDX_PER3)) begin
                cfg_d.period[27:24] = hwdata[3:0];
            end else if (wr_addr_q == hha_pkg::addr_of(hha_pkg::IDX_COND)) begin
                cfg_d.cond = hwdata[5:0];
            end else if (wr_addr_q == hha_pkg::addr_of(hha_pkg::IDX_HOLD)) begin
                cfg_d.holdoff = hwdata[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 32'h00000000;
            rdata_q <= 32'h00000000;
            cfg_q <= {hha_pkg::RST_PERIOD, hha_pkg::RST_COND, hha_pkg::RST_HOLD};
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            rdata_q <= rdata_d;
            cfg_q <= cfg_d;
        end
    end

    // ---------------- millisecond tick ----------------
    logic [hha_pkg::TICK_W-1:0] tick_cnt_q, tick_cnt_d;
    logic ms_tick;

    // free-running divider so the hold-off and period counters share one time base
    always_comb begin
        ms_tick = (tick_cnt_q == hha_pkg::TICK_W'(MS_TICK_CYCLES - 1));
        tick_cnt_d = ms_tick ? '0 : tick_cnt_q + 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    // ---------------- start control and accumulation ----------------
    logic [hha_pkg::HOLD_W-1:0] hold_cnt_q, hold_cnt_d;
    logic [hha_pkg::PER_W-1:0] per_cnt_q, per_cnt_d;
    logic [hha_pkg::ACC_W-1:0] acc_q, acc_d;
    logic [hha_pkg::ACC_W-1:0] acc_sum;
    logic fl_delay, period_done;

    assign fl_delay = cfg_q.cond[hha_pkg::COND_FL_DELAY_BIT];
    assign acc_sum = acc_q + hha_pkg::ACC_W'(tuning_word);
    assign period_done = ms_tick && (per_cnt_q + 1'b1 == cfg_q.period);
    assign averaging = (state_q == hha_pkg::ST_AVERAGE);

    // losing lock while gated restarts acquisition and drops the partial sum
    always_comb begin
        state_d = state_q;
        hold_cnt_d = hold_cnt_q;
        per_cnt_d = per_cnt_q;
        acc_d = acc_q;
        case (state_q)
            hha_pkg::ST_WAIT_LOCK: begin
                hold_cnt_d = '0;
                if (!fl_delay) begin
                    state_d = hha_pkg::ST_AVERAGE;
                end else if (freq_locked) begin
                    if (cfg_q.holdoff == '0) begin
                        state_d = hha_pkg::ST_AVERAGE;
                    end else begin
                        state_d = hha_pkg::ST_HOLDOFF;
                    end
                end
            end
            hha_pkg::ST_HOLDOFF: begin
                if (!freq_locked && fl_delay) begin
                    state_d = hha_pkg::ST_WAIT_LOCK;
                end else if (!fl_delay) begin
                    // clearing the bit mid hold-off must not stall averaging
                    state_d = hha_pkg::ST_AVERAGE;
                end else if (ms_tick) begin
                    hold_cnt_d = hold_cnt_q + 1'b1;
                    if (hold_cnt_q + 1'b1 >= cfg_q.holdoff) begin
                        state_d = hha_pkg::ST_AVERAGE;
                    end
                end
            end
            hha_pkg::ST_AVERAGE: begin
                if (fl_delay && !freq_locked) begin
                    state_d = hha_pkg::ST_WAIT_LOCK;
                    per_cnt_d = '0;
                    acc_d = '0;
                end else if (ms_tick) begin
                    // one sample per millisecond, so the count equals the period
                    if (period_done) begin
                        per_cnt_d = '0;
                        acc_d = '0;
                    end else begin
                        per_cnt_d = per_cnt_q + 1'b1;
                        acc_d = acc_sum;
                    end
                end
            end
            default: begin
                state_d = hha_pkg::ST_WAIT_LOCK;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= hha_pkg::ST_WAIT_LOCK;
            hold_cnt_q <= '0;
            per_cnt_q <= '0;
            acc_q <= '0;
        end else begin
            state_q <= state_d;
            hold_cnt_q <= hold_cnt_d;
            per_cnt_q <= per_cnt_d;
            acc_q <= acc_d;
        end
    end

    // ---------------- sequential divider ----------------
    // restoring division, one bit a cycle: far shorter than a millisecond
    logic [hha_pkg::ACC_W-1:0] quo_q, quo_d;
    logic [hha_pkg::PER_W:0] rem_q, rem_d;
    logic [hha_pkg::PER_W-1:0] dvs_q, dvs_d;
    logic [hha_pkg::DIV_CNT_W-1:0] div_cnt_q, div_cnt_d;
    logic [hha_pkg::PER_W:0] rem_sh;
    logic div_start;

    assign div_start = averaging && period_done && !(fl_delay && !freq_locked);

    always_comb begin
        quo_d = quo_q;
        rem_d = rem_q;
        dvs_d = dvs_q;
        div_cnt_d = div_cnt_q;
        div_busy_d = div_busy_q;
        avg_d = avg_q;
        rem_sh = {rem_q[hha_pkg::PER_W-1:0], quo_q[hha_pkg::ACC_W-1]};
        if (div_start) begin
            quo_d = acc_sum;
            rem_d = '0;
            dvs_d = cfg_q.period;
            div_cnt_d = '0;
            div_busy_d = 1'b1;
        end else if (div_busy_q) begin
            if (rem_sh >= {1'b0, dvs_q}) begin
                rem_d = rem_sh - {1'b0, dvs_q};
                quo_d = {quo_q[hha_pkg::ACC_W-2:0], 1'b1};
            end else begin
                rem_d = rem_sh;
                quo_d = {quo_q[hha_pkg::ACC_W-2:0], 1'b0};
            end
            div_cnt_d = div_cnt_q + 1'b1;
            if (div_cnt_q == hha_pkg::DIV_CNT_W'(hha_pkg::ACC_W - 1)) begin
                div_busy_d = 1'b0;
                avg_d.word = quo_d[hha_pkg::TW_W-1:0];
                avg_d.valid = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quo_q <= '0;
            rem_q <= '0;
            dvs_q <= '0;
            div_cnt_q <= '0;
            div_busy_q <= 1'b0;
            avg_q <= '0;
        end else begin
            quo_q <= quo_d;
            rem_q <= rem_d;
            dvs_q <= dvs_d;
            div_cnt_q <= div_cnt_d;
            div_busy_q <= div_busy_d;
            avg_q <= avg_d;
        end
    end

    assign holdover = avg_q;

endmodule

//--- hha_pkg.sv
package hha_pkg;

    // datapath widths
    localparam int TW_W = 32;
    localparam int PER_W = 28;
    localparam int HOLD_W = 8;
    localparam int ACC_W = TW_W + PER_W;
    localparam int COND_W = 6;
    localparam int TICK_W = 14;
    localparam int DIV_CNT_W = 6;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_PER0 = 16'h140A;
    localparam logic [15:0] IDX_PER1 = 16'h140B;
    localparam logic [15:0] IDX_PER2 = 16'h140C;
    localparam logic [15:0] IDX_PER3 = 16'h140D;
    localparam logic [15:0] IDX_COND = 16'h140E;
    localparam logic [15:0] IDX_HOLD = 16'h1410;
    localparam logic [15:0] IDX_STAT = 16'h1420;
    localparam logic [15:0] IDX_AVG = 16'h1421;

    // reset values
    localparam logic [PER_W-1:0] RST_PERIOD = 28'h000000A;
    localparam logic [COND_W-1:0] RST_COND = 6'h18;
    localparam logic [HOLD_W-1:0] RST_HOLD = 8'h00;

    // field positions
    localparam int COND_FL_DELAY_BIT = 4;
    localparam int STAT_VALID_BIT = 2;
    localparam int STAT_BUSY_BIT = 3;

    // timing: one millisecond at the bus clock rate
    localparam int MS_NS = 1000000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        ST_WAIT_LOCK = 2'b00,
        ST_HOLDOFF = 2'b01,
        ST_AVERAGE = 2'b10
    } hha_state_e;

    typedef struct packed {
        logic [PER_W-1:0] period;
        logic [COND_W-1:0] cond;
        logic [HOLD_W-1:0] holdoff;
    } hha_cfg_s;

    typedef struct packed {
        logic [TW_W-1:0] word;
        logic valid;
    } hha_avg_s;

    // byte address of a register index
    function automatic logic [31:0] addr_of(input logic [15:0] idx);
        return {14'h0000, idx, 2'b00};
    endfunction

endpackage

//--- hha_averager_checker.sv
module hha_checker #(
    parameter int MS_TICK_CYCLES = hha_pkg::MS_CYCLES // cycles per ms tick
) (
    input wire logic hclk, // clock
    input wire logic hresetn, // reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    input wire logic freq_locked, // lock input
    input wire hha_pkg::hha_avg_s holdover, // averaged word
    input wire logic averaging // accumulating
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wr_q;
    logic [31:0] wa_q;
    logic dly_q;
    logic [7:0] ho_q;
    logic [7:0] per_q;
    logic [15:0] lk_q;
    logic [31:0] av_q;
    int lo_ho, hi_ho, lo_av, hi_av;

    // config shadow; only period[7:0] kept, so the period check needs upper bytes zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            wa_q <= 32'h00000000;
            dly_q <= 1'b1;
            ho_q <= 8'h00;
            per_q <= 8'h0A;
            lk_q <= 16'h0000;
            av_q <= 32'h00000000;
        end else begin
            wr_q <= hsel && hready && htrans == hha_pkg::HTRANS_NONSEQ && hwrite;
            wa_q <= haddr;
            if (wr_q && wa_q == hha_pkg::addr_of(hha_pkg::IDX_COND)) dly_q <= hwdata[4];
            if (wr_q && wa_q == hha_pkg::addr_of(hha_pkg::IDX_HOLD)) ho_q <= hwdata[7:0];
            if (wr_q && wa_q == hha_pkg::addr_of(hha_pkg::IDX_PER0)) per_q <= hwdata[7:0];
            lk_q <= freq_locked ? lk_q + 16'h0001 : 16'h0000;
            av_q <= averaging ? av_q + 32'h00000001 : 32'h00000000;
        end
    end

    // tick phase is free-running, hence one ms of slack in each window
    always_comb begin
        lo_ho = (int'(ho_q) - 1) * MS_TICK_CYCLES + 1;
        hi_ho = int'(ho_q) * MS_TICK_CYCLES + 3;
        lo_av = (int'(per_q) - 1) * MS_TICK_CYCLES + 59;
        hi_av = int'(per_q) * MS_TICK_CYCLES + 62;
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_lock_start;
        $rose(averaging) && dly_q;
    endsequence

    a_lock_gate: assert property (dly_q && !freq_locked |=> !averaging)
        else $error("averaging while unlocked with lock delay set");
    a_free_run: assert property (!dly_q |-> ##[1:2] averaging)
        else $error("averaging idle with lock delay clear");
    a_no_holdoff: assert property (s_lock_start ##0 ho_q == 8'h00 |-> lk_q inside {[1:2]})
        else $error("zero hold-off did not start at lock");
    a_holdoff_min: assert property (s_lock_start ##0 ho_q != 8'h00 |-> lk_q >= lo_ho)
        else $error("averaging started before hold-off ran out");
    a_holdoff_max: assert property (s_lock_start ##0 ho_q != 8'h00 |-> lk_q <= hi_ho)
        else $error("hold-off lasted too long");
    a_first_avg: assert property ($rose(holdover.valid) |-> av_q inside {[lo_av:hi_av]})
        else $error("first average not after period ms");
    a_valid_stick: assert property (holdover.valid |=> holdover.valid)
        else $error("holdover valid dropped");
    a_word_upd: assert property ($changed(holdover.word) |-> holdover.valid)
        else $error("holdover word changed without valid");
endmodule

bind hha_averager hha_checker #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) i_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .freq_locked(freq_locked),
    .holdover(holdover), .averaging(averaging));

//--- holdover_history_averager_tb.sv
module holdover_history_averager_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MS = 100;
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, freq_locked, hreadyout, hresp, averaging;
    logic [31:0] haddr, hwdata, hrdata, tuning_word, tw;
    logic [31:0] last_w = 32'h00000000;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic rd_ph = 1'b0;
    wire hready = hreadyout;
    hha_pkg::hha_avg_s holdover;
    logic [31:0] exp_q[$];
    logic [31:0] hold_q[$];
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    int seed = 32'h9572766B;

    always #50 hclk = ~hclk;

    hha_averager #(.MS_TICK_CYCLES(MS)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .tuning_word(tuning_word), .freq_locked(freq_locked), .holdover(holdover),
        .averaging(averaging));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // one word transfer; a read notes the expected data for the monitor
    task automatic bus(input logic [15:0] idx, input logic wr, input logic [31:0] val);
        if (!wr) exp_q.push_back(val);
        hsel <= 1'b1;
        haddr <= hha_pkg::addr_of(idx);
        hwrite <= wr;
        htrans <= hha_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= val;
        do @(posedge hclk); while (hready !== 1'b1);
    endtask

    // sampled at the falling edge so hrdata has settled
    always @(posedge hclk) rd_ph <= hresetn && hsel && htrans == hha_pkg::HTRANS_NONSEQ && !hwrite;
    always @(negedge hclk) begin
        if (rd_ph && exp_q.size() > 0) check(hrdata, exp_q.pop_front(), "register");
        if (rd_ph) check({30'h0, hreadyout, hresp}, 32'h00000002, "ready and okay");
        if (holdover.word !== last_w) begin
            check({31'h0, holdover.valid}, 32'h00000001, "avg valid");
            check(holdover.word, hold_q.size() > 0 ? hold_q.pop_front() : last_w, "avg");
            last_w = holdover.word;
        end
    end

    // hang guard
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        tuning_word = 32'h00000000;
        freq_locked = 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(hha_pkg::IDX_PER0, 1'b0, 32'h0000000A);
        bus(hha_pkg::IDX_PER3, 1'b0, 32'h00000000);
        bus(hha_pkg::IDX_COND, 1'b0, 32'h00000018);
        bus(hha_pkg::IDX_HOLD, 1'b0, 32'h00000000);
        bus(16'h1500, 1'b0, 32'h00000000);
        bus(hha_pkg::IDX_PER3, 1'b1, 32'h000000FF);
        bus(hha_pkg::IDX_PER3, 1'b0, 32'h0000000F);
        bus(hha_pkg::IDX_PER3, 1'b1, 32'h00000000);
        bus(hha_pkg::IDX_PER0, 1'b1, 32'h00000003); // period kept nonzero
        tw = $random(seed);
        tuning_word <= tw;
        repeat (3 * MS) @(posedge hclk);
        bus(hha_pkg::IDX_STAT, 1'b0, 32'h00000000);
        // zero hold-off: averaging right at lock
        freq_locked <= 1'b1;
        repeat (3) @(posedge hclk);
        bus(hha_pkg::IDX_STAT, 1'b0, 32'h00000002);
        freq_locked <= 1'b0;
        bus(hha_pkg::IDX_HOLD, 1'b1, 32'h00000002);
        freq_locked <= 1'b1;
        repeat (MS - 5) @(posedge hclk);
        bus(hha_pkg::IDX_STAT, 1'b0, 32'h00000001);
        hold_q.push_back(tw);
        for (int i = 0; i < 8 * MS && hold_q.size() > 0; i++) @(posedge hclk);
        bus(hha_pkg::IDX_AVG, 1'b0, tw);
        // lock loss drops the partial sum; then run with lock delay off
        freq_locked <= 1'b0;
        tw = $random(seed);
        tuning_word <= tw;
        hold_q.push_back(tw);
        bus(hha_pkg::IDX_COND, 1'b1, 32'h00000008);
        // state follows the cleared bit one cycle after the write lands
        @(posedge hclk);
        bus(hha_pkg::IDX_STAT, 1'b0, 32'h00000006);
        for (int i = 0; i < 8 * MS && hold_q.size() > 0; i++) @(posedge hclk);
        bus(hha_pkg::IDX_AVG, 1'b0, tw);
        end_of_test();
    end
endmodule
